//--- pio_pad.sv
`timescale 1ns/1ns
// Pin driver decode: low is always driven when enabled, high only in push-pull
module pio_pad #(
   parameter int W = 8
) (
   input  wire logic [W-1:0] val,      // Level to present
   input  wire logic [W-1:0] en,       // Pin acts as output
   input  wire logic [W-1:0] push,     // 1 push-pull, 0 sink open-drain
   output logic      [W-1:0] pin_out,  // Pin output level
   output logic      [W-1:0] pin_oe    // Pin output enable, high drives
);
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         // Drive low for a zero, drive high only with push-pull
         assign pin_out[i] = val[i];
         assign pin_oe[i]  = en[i] & (push[i] | ~val[i]);
      end
   endgenerate
endmodule // pio_pad

//--- pio_pins.sv
`timescale 1ns/1ns
// Outside circuit on a port: a driven pin shows the port's level, else the outside source
module pio_pins #(
   parameter int W = 8
) (
   input  wire logic [W-1:0] pin_out,   // Port drive level
   input  wire logic [W-1:0] pin_oe,    // Port drive enable
   input  wire logic [W-1:0] ext_level, // Level of the outside source
   output logic      [W-1:0] pin_in     // Resolved pin level
);
   // Outside source level passes straight through on every bit the port does not drive
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // pio_pins

//--- pio_pkg.sv
package pio_pkg;

   // Port widths
   localparam int P1_W = 8;
   localparam int P2_W = 3;
   localparam int P4_W = 8;
   localparam int P5_W = 3;
   localparam int PIN_W = P1_W + P2_W + P4_W + P5_W;

   // Register offsets on the byte address port
   localparam logic [7:0] P1_LATCH_OFS  = 8'h01;
   localparam logic [7:0] P2_LATCH_OFS  = 8'h02;
   localparam logic [7:0] P4_LATCH_OFS  = 8'h04;
   localparam logic [7:0] P5_LATCH_OFS  = 8'h05;
   localparam logic [7:0] P1_DRIVE_OFS  = 8'h0b;
   localparam logic [7:0] P4_DIR_OFS    = 8'h0c;
   localparam logic [7:0] P5_DIR_OFS    = 8'h0d;
   localparam logic [7:0] P1_SAMPLE_OFS = 8'h15;
   localparam logic [7:0] P2_SAMPLE_OFS = 8'h16;
   localparam logic [7:0] P4_GATE_OFS   = 8'h28;
   localparam logic [7:0] TSS_OFS       = 8'h29;

   // Field positions in the timer/serial pin select register
   localparam int TSS_INV_BIT   = 0;
   localparam int TSS_ROUTE_BIT = 5;
   localparam int TSS_CHIP_BIT  = 7;

   // Values after reset
   localparam logic [7:0] P1_LATCH_RST = 8'hff;
   localparam logic [7:0] P1_DRIVE_RST = 8'h00;
   localparam logic [2:0] P2_LATCH_RST = 3'h7;
   localparam logic [7:0] P4_LATCH_RST = 8'h00;
   localparam logic [7:0] P4_DIR_RST   = 8'h00;
   localparam logic [7:0] P4_GATE_RST  = 8'hff;
   localparam logic [2:0] P5_LATCH_RST = 3'h0;
   localparam logic [2:0] P5_DIR_RST   = 3'h0;
   localparam logic       TSS_BIT_RST  = 1'b0;

endpackage

//--- pio_ports.sv
//  Overview of operation
// - Reset: port1 latch ones, drive select zeros
// - Port1: zero drives low, one per select
// - Port1 latch reads latch; sample reads pins
// - Invert bit flips timer3 input; resets zero
// - Pins sampled in the read cycle; code reads synced pins, two clocks old
// - Pins change in the cycle after the write strobe
// - Port2 three bits, latch ones, high bits zero
// - P20 released during stop mode
// - P20 falling edge raises interrupt event
// - Port4 direction one output, zero input
// - Reset: port4 direction zero, gate ones, latch zero
// - Port4 gate zero open-drain, one push-pull
// - Gate zero reads zero, blocks input gate
// - Input-mode bits read back pin levels
// - Port5 three bits, direction and latch zero
`timescale 1ns/1ns
module pio_ports (
   input  wire logic                          mclk,          // System clock, 100 MHz
   input  wire logic                          rst,           // Async reset, active high
   input  wire logic [7:0]                    reg_addr,      // Register address
   input  wire logic [7:0]                    reg_wdata,     // Write data
   input  wire logic                          reg_wr,        // Write strobe
   input  wire logic                          reg_rd,        // Read strobe
   output logic      [7:0]                    reg_rdata,     // Read data, cycle after strobe
   input  wire logic                          stop_mode,     // Device in stop mode
   input  wire logic [pio_pkg::P1_W-1:0]      p1_alt_out,    // Port1 function outputs
   input  wire logic                          sio_data_out,  // Clocked serial data out
   input  wire logic                          bus_clk_out,   // Two-wire bus clock out
   input  wire logic [pio_pkg::P1_W-1:0]      p1_pin_in,     // Port1 pin levels
   output logic      [pio_pkg::P1_W-1:0]      p1_pin_out,    // Port1 pin drive level
   output logic      [pio_pkg::P1_W-1:0]      p1_pin_oe,     // Port1 pin drive enable
   input  wire logic [pio_pkg::P2_W-1:0]      p2_pin_in,     // Port2 pin levels
   output logic      [pio_pkg::P2_W-1:0]      p2_pin_out,    // Port2 pin drive level
   output logic      [pio_pkg::P2_W-1:0]      p2_pin_oe,     // Port2 pin drive enable
   input  wire logic [pio_pkg::P4_W-1:0]      p4_pin_in,     // Port4 pin levels
   output logic      [pio_pkg::P4_W-1:0]      p4_pin_out,    // Port4 pin drive level
   output logic      [pio_pkg::P4_W-1:0]      p4_pin_oe,     // Port4 pin drive enable
   output logic      [pio_pkg::P4_W-1:0]      p4_input_gate, // Port4 digital input gate on
   input  wire logic [pio_pkg::P5_W-1:0]      p5_pin_in,     // Port5 pin levels
   output logic      [pio_pkg::P5_W-1:0]      p5_pin_out,    // Port5 pin drive level
   output logic      [pio_pkg::P5_W-1:0]      p5_pin_oe,     // Port5 pin drive enable
   output logic      [pio_pkg::P1_W-1:0]      p1_func_in,    // Synced port1 for functions
   output logic      [pio_pkg::P5_W-1:0]      p5_func_in,    // Synced port5 for functions
   output logic                               timer3_input,  // Timer3 external input
   output logic                               serial_pin_route,     // P15 route select
   output logic                               chip_enable_function, // Chip enable on
   output logic                               chip_select_n, // Serial chip select, low on
   output logic                               p20_fall_event // P20 falling edge pulse
);
   import pio_pkg::*;

   // Read-back of a directional port: output bits show latch, input bits show pins
   function automatic logic [7:0] rd_port(input logic [7:0] dir,
                                          input logic [7:0] latch,
                                          input logic [7:0] pin);
      rd_port = (dir & latch) | (~dir & pin);
   endfunction

   // Control registers
   logic [P1_W-1:0] p1_latch_reg;
   logic [P1_W-1:0] p1_latch_next;
   logic [P1_W-1:0] p1_drive_reg;
   logic [P1_W-1:0] p1_drive_next;
   logic [P2_W-1:0] p2_latch_reg;
   logic [P2_W-1:0] p2_latch_next;
   logic [P4_W-1:0] p4_latch_reg;
   logic [P4_W-1:0] p4_latch_next;
   logic [P4_W-1:0] p4_dir_reg;
   logic [P4_W-1:0] p4_dir_next;
   logic [P4_W-1:0] p4_gate_reg;
   logic [P4_W-1:0] p4_gate_next;
   logic [P5_W-1:0] p5_latch_reg;
   logic [P5_W-1:0] p5_latch_next;
   logic [P5_W-1:0] p5_dir_reg;
   logic [P5_W-1:0] p5_dir_next;
   logic            tss_inv_reg;
   logic            tss_inv_next;
   logic            tss_route_reg;
   logic            tss_route_next;
   logic            tss_chip_reg;
   logic            tss_chip_next;

   // Read path and function outputs
   logic [7:0]      rdata_reg;
   logic [7:0]      rdata_next;
   logic            p20_prev_reg;
   logic            p20_prev_next;
   logic            p20_fall_reg;
   logic            p20_fall_next;
   logic            timer3_reg;
   logic            timer3_next;
   logic            chip_sel_reg;
   logic            chip_sel_next;

   // Synchronised pins
   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] pin_sync;
   logic [P1_W-1:0]  p1_sync;
   logic [P2_W-1:0]  p2_sync;
   logic [P4_W-1:0]  p4_sync;
   logic [P5_W-1:0]  p5_sync;

   // Pad control
   logic [P1_W-1:0]  p1_func;
   logic [P1_W-1:0]  p1_val;
   logic [P2_W-1:0]  p2_en;

   // All pins pass two flops before any read or function logic
   assign pin_raw = {p5_pin_in, p4_pin_in, p2_pin_in, p1_pin_in};

   pio_sync #(.W(PIN_W)) u_sync (
      .mclk (mclk),
      .rst  (rst),
      .d    (pin_raw),
      .q    (pin_sync)
   );

   assign p1_sync = pin_sync[P1_W-1:0];
   assign p2_sync = pin_sync[P1_W+P2_W-1:P1_W];
   assign p4_sync = pin_sync[P1_W+P2_W+P4_W-1:P1_W+P2_W];
   assign p5_sync = pin_sync[PIN_W-1:P1_W+P2_W+P4_W];

   // Register writes on the clock from the write strobe
   always_comb begin
      p1_latch_next  = p1_latch_reg;
      p1_drive_next  = p1_drive_reg;
      p2_latch_next  = p2_latch_reg;
      p4_latch_next  = p4_latch_reg;
      p4_dir_next    = p4_dir_reg;
      p4_gate_next   = p4_gate_reg;
      p5_latch_next  = p5_latch_reg;
      p5_dir_next    = p5_dir_reg;
      tss_inv_next   = tss_inv_reg;
      tss_route_next = tss_route_reg;
      tss_chip_next  = tss_chip_reg;
      if (reg_wr) begin
         case (reg_addr)
            P1_LATCH_OFS: p1_latch_next = reg_wdata;
            P1_DRIVE_OFS: p1_drive_next = reg_wdata;
            P2_LATCH_OFS: p2_latch_next = reg_wdata[P2_W-1:0];
            P4_LATCH_OFS: p4_latch_next = reg_wdata;
            P4_DIR_OFS:   p4_dir_next   = reg_wdata;
            P4_GATE_OFS:  p4_gate_next  = reg_wdata;
            P5_LATCH_OFS: p5_latch_next = reg_wdata[P5_W-1:0];
            P5_DIR_OFS:   p5_dir_next   = reg_wdata[P5_W-1:0];
            TSS_OFS: begin
               tss_inv_next   = reg_wdata[TSS_INV_BIT];
               tss_route_next = reg_wdata[TSS_ROUTE_BIT];
               tss_chip_next  = reg_wdata[TSS_CHIP_BIT];
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         p1_latch_reg  <= P1_LATCH_RST;
         p1_drive_reg  <= P1_DRIVE_RST;
         p2_latch_reg  <= P2_LATCH_RST;
         p4_latch_reg  <= P4_LATCH_RST;
         p4_dir_reg    <= P4_DIR_RST;
         p4_gate_reg   <= P4_GATE_RST;
         p5_latch_reg  <= P5_LATCH_RST;
         p5_dir_reg    <= P5_DIR_RST;
         tss_inv_reg   <= TSS_BIT_RST;
         tss_route_reg <= TSS_BIT_RST;
         tss_chip_reg  <= TSS_BIT_RST;
      end else begin
         p1_latch_reg  <= p1_latch_next;
         p1_drive_reg  <= p1_drive_next;
         p2_latch_reg  <= p2_latch_next;
         p4_latch_reg  <= p4_latch_next;
         p4_dir_reg    <= p4_dir_next;
         p4_gate_reg   <= p4_gate_next;
         p5_latch_reg  <= p5_latch_next;
         p5_dir_reg    <= p5_dir_next;
         tss_inv_reg   <= tss_inv_next;
         tss_route_reg <= tss_route_next;
         tss_chip_reg  <= tss_chip_next;
      end
   end

   // Read mux: synchronised pins, two clocks old, are sampled in the strobe cycle, data stands one cycle only
   always_comb begin
      rdata_next = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            P1_LATCH_OFS:  rdata_next = p1_latch_reg;
            P1_DRIVE_OFS:  rdata_next = p1_drive_reg;
            P1_SAMPLE_OFS: rdata_next = p1_sync;
            P2_LATCH_OFS:  rdata_next = {5'h00, p2_latch_reg};
            P2_SAMPLE_OFS: rdata_next = {5'h00, p2_sync};
            P4_LATCH_OFS:  rdata_next = rd_port(p4_dir_reg, p4_latch_reg,
                                                p4_sync & p4_gate_reg);
            P4_DIR_OFS:    rdata_next = p4_dir_reg;
            P4_GATE_OFS:   rdata_next = p4_gate_reg;
            P5_LATCH_OFS:  rdata_next = rd_port({5'h00, p5_dir_reg},
                                                {5'h00, p5_latch_reg},
                                                {5'h00, p5_sync});
            P5_DIR_OFS:    rdata_next = {5'h00, p5_dir_reg};
            TSS_OFS:       rdata_next = {tss_chip_reg, 1'b0, tss_route_reg,
                                         4'h0, tss_inv_reg};
            default:       rdata_next = 8'h00;
         endcase
      end
   end

   // Function inputs derived from synchronised pins
   always_comb begin
      timer3_next   = p1_sync[0] ^ tss_inv_reg;
      chip_sel_next = tss_chip_reg ? p1_sync[P1_W-1] : 1'b1;
      p20_prev_next = p2_sync[0];
      p20_fall_next = p20_prev_reg & ~p2_sync[0];
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rdata_reg    <= 8'h00;
         timer3_reg   <= 1'b0;
         chip_sel_reg <= 1'b1;
         p20_prev_reg <= 1'b0;
         p20_fall_reg <= 1'b0;
      end else begin
         rdata_reg    <= rdata_next;
         timer3_reg   <= timer3_next;
         chip_sel_reg <= chip_sel_next;
         p20_prev_reg <= p20_prev_next;
         p20_fall_reg <= p20_fall_next;
      end
   end

   // P15 carries serial data or the bus clock; functions pass only with latch high
   always_comb begin
      p1_func                = p1_alt_out;
      p1_func[TSS_ROUTE_BIT] = tss_route_reg ? bus_clk_out : sio_data_out;
      p1_val                 = p1_latch_reg & p1_func;
   end

   // Port1: low always driven, high only with drive select set
   pio_pad #(.W(P1_W)) u_pad_p1 (
      .val     (p1_val),
      .en      ({P1_W{1'b1}}),
      .push    (p1_drive_reg),
      .pin_out (p1_pin_out),
      .pin_oe  (p1_pin_oe)
   );

   // Port2 is sink-only; P20 is released in stop mode
   assign p2_en = {{(P2_W-1){1'b1}}, ~stop_mode};

   pio_pad #(.W(P2_W)) u_pad_p2 (
      .val     (p2_latch_reg),
      .en      (p2_en),
      .push    ({P2_W{1'b0}}),
      .pin_out (p2_pin_out),
      .pin_oe  (p2_pin_oe)
   );

   // Port4: direction picks output, gate/drive picks push-pull or open-drain
   pio_pad #(.W(P4_W)) u_pad_p4 (
      .val     (p4_latch_reg),
      .en      (p4_dir_reg),
      .push    (p4_gate_reg),
      .pin_out (p4_pin_out),
      .pin_oe  (p4_pin_oe)
   );

   // Digital input gate closed while gate/drive holds zero
   assign p4_input_gate = p4_gate_reg;

   // Port5: push-pull per direction bit
   pio_pad #(.W(P5_W)) u_pad_p5 (
      .val     (p5_latch_reg),
      .en      (p5_dir_reg),
      .push    ({P5_W{1'b1}}),
      .pin_out (p5_pin_out),
      .pin_oe  (p5_pin_oe)
   );

   // Outputs
   assign reg_rdata            = rdata_reg;
   assign p1_func_in           = p1_sync;
   assign p5_func_in           = p5_sync;
   assign timer3_input         = timer3_reg;
   assign serial_pin_route     = tss_route_reg;
   assign chip_enable_function = tss_chip_reg;
   assign chip_select_n        = chip_sel_reg;
   assign p20_fall_event       = p20_fall_reg;

endmodule // pio_ports

//--- pio_ports_chk.sv
`timescale 1ns/1ns
// Port-level checks of the parallel port block
module pio_ports_chk (
   input wire logic       mclk,                 // System clock
   input wire logic       rst,                  // Async reset
   input wire logic [7:0] reg_addr,             // Address
   input wire logic [7:0] reg_wdata,            // Write data
   input wire logic       reg_wr,               // Write strobe
   input wire logic       reg_rd,               // Read strobe
   input wire logic [7:0] reg_rdata,            // Read data
   input wire logic       stop_mode,            // Stop mode
   input wire logic       sio_data_out,         // Serial data
   input wire logic       bus_clk_out,          // Bus clock
   input wire logic [7:0] p1_pin_in,            // Port1 pins
   input wire logic [7:0] p1_pin_out,           // Port1 level
   input wire logic [7:0] p1_pin_oe,            // Port1 enable
   input wire logic [2:0] p2_pin_in,            // Port2 pins
   input wire logic [2:0] p2_pin_oe,            // Port2 enable
   input wire logic [7:0] p4_pin_out,           // Port4 level
   input wire logic [7:0] p4_pin_oe,            // Port4 enable
   input wire logic [7:0] p4_input_gate,        // Port4 gate
   input wire logic [2:0] p5_pin_out,           // Port5 level
   input wire logic [7:0] p1_func_in,           // Synced port1
   input wire logic       serial_pin_route,     // Route bit
   input wire logic       chip_enable_function, // Chip enable bit
   input wire logic       chip_select_n,        // Chip select
   input wire logic       p20_fall_event        // Fall pulse
);
   import pio_pkg::*;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // Tracks the P15 latch bit from bus writes
   logic p15_latch_reg;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         p15_latch_reg <= P1_LATCH_RST[5];
      end else if (reg_wr && reg_addr == P1_LATCH_OFS) begin
         p15_latch_reg <= reg_wdata[5];
      end
   end
   // Bus cycles that the checks start from
   sequence s_p1_read;
      reg_rd && reg_addr == P1_SAMPLE_OFS;
   endsequence
   sequence s_p5_write;
      reg_wr && reg_addr == P5_LATCH_OFS;
   endsequence
   // Read data, pin drive and status relations
   a_rdata_idle: assert property (reg_rdata != 8'h00 |-> $past(reg_rd))
      else $error("read data outside a read cycle");
   a_p1_sample: assert property (s_p1_read |=> reg_rdata == $past(p1_pin_in, 3))
      else $error("port1 sample read wrong");
   a_p5_write: assert property (s_p5_write |=> p5_pin_out == $past(reg_wdata[2:0]))
      else $error("port5 pins did not follow write");
   a_p1_low_drive: assert property ((~p1_pin_out & ~p1_pin_oe) == 8'h00)
      else $error("port1 low level not driven");
   a_p4_open_drain: assert property ((p4_pin_oe & p4_pin_out & ~p4_input_gate) == 8'h00)
      else $error("port4 drives high in open drain");
   a_p20_stop: assert property (stop_mode |-> !p2_pin_oe[0])
      else $error("P20 driven in stop mode");
   a_p15_route: assert property (p1_pin_out[5] ==
      (p15_latch_reg && (serial_pin_route ? bus_clk_out : sio_data_out)))
      else $error("P15 source wrong");
   a_cs_gate: assert property (chip_select_n ==
      ($past(chip_enable_function) ? $past(p1_func_in[7]) : 1'b1))
      else $error("chip select not gated by enable");
   a_fall_once: assert property (p20_fall_event |->
      ($past(p2_pin_in[0], 3) == 1'b0 && $past(p2_pin_in[0], 4) == 1'b1) ##1 !p20_fall_event)
      else $error("P20 fall pulse wrong");
endmodule // pio_ports_chk

bind pio_ports pio_ports_chk u_chk (
   .mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .stop_mode,
   .sio_data_out, .bus_clk_out, .p1_pin_in, .p1_pin_out, .p1_pin_oe, .p2_pin_in,
   .p2_pin_oe, .p4_pin_out, .p4_pin_oe, .p4_input_gate, .p5_pin_out, .p1_func_in,
   .serial_pin_route, .chip_enable_function, .chip_select_n, .p20_fall_event
);

//--- pio_ports_tb.sv
`timescale 1ns/1ns
module pio_ports_tb;
   import pio_pkg::*;
   logic       mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, stop_mode = 1'b0;
   logic       sio_data_out = 1'b1, bus_clk_out = 1'b1;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, p1_alt_out = 8'hff;
   logic [7:0] ext1 = 8'hff, ext4 = 8'h5a, l, d, g, s, n;
   logic [2:0] ext2 = 3'h7, ext5 = 3'h5;
   logic [7:0] reg_rdata, p1_pin_in, p1_pin_out, p1_pin_oe, p4_pin_in, p4_pin_out;
   logic [7:0] p4_pin_oe, p4_input_gate, p1_func_in;
   logic [2:0] p2_pin_in, p2_pin_out, p2_pin_oe, p5_pin_in, p5_pin_out, p5_pin_oe, p5_func_in;
   logic       timer3_input, serial_pin_route, chip_enable_function, chip_select_n;
   logic       p20_fall_event;
   integer     seed = 15;
   int         fail_count = 0, samples_checked = 0;
   logic [7:0] rst_addr [10] = '{8'h03, 8'h01, 8'h0b, 8'h02, 8'h0c, 8'h0d, 8'h28, 8'h29,
                                 8'h04, 8'h05};
   logic [7:0] rst_exp [10] = '{8'h00, 8'hff, 8'h00, 8'h07, 8'h00, 8'h00, 8'hff, 8'h00,
                                8'h5a, 8'h05};

   always #5 mclk = ~mclk;

   // Device and the outside circuits on its pins
   pio_ports uut (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .stop_mode,
      .p1_alt_out, .sio_data_out, .bus_clk_out, .p1_pin_in, .p1_pin_out, .p1_pin_oe,
      .p2_pin_in, .p2_pin_out, .p2_pin_oe, .p4_pin_in, .p4_pin_out, .p4_pin_oe, .p4_input_gate,
      .p5_pin_in, .p5_pin_out, .p5_pin_oe, .p1_func_in, .p5_func_in, .timer3_input,
      .serial_pin_route, .chip_enable_function, .chip_select_n, .p20_fall_event);
   pio_pins #(.W(8)) u_p1 (.pin_out(p1_pin_out), .pin_oe(p1_pin_oe), .ext_level(ext1),
      .pin_in(p1_pin_in));
   pio_pins #(.W(3)) u_p2 (.pin_out(p2_pin_out), .pin_oe(p2_pin_oe), .ext_level(ext2),
      .pin_in(p2_pin_in));
   pio_pins #(.W(8)) u_p4 (.pin_out(p4_pin_out), .pin_oe(p4_pin_oe), .ext_level(ext4),
      .pin_in(p4_pin_in));
   pio_pins #(.W(3)) u_p5 (.pin_out(p5_pin_out), .pin_oe(p5_pin_oe), .ext_level(ext5),
      .pin_in(p5_pin_in));

   // Per-bit pick: sel 1 takes a, sel 0 takes b
   function automatic logic [7:0] mix(input logic [7:0] sel, input logic [7:0] a,
                                      input logic [7:0] b);
      return (sel & a) | (~sel & b);
   endfunction

   // Compare, bus write and bus read
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(negedge mclk);
      chk(what, exp, reg_rdata);
   endtask
   task automatic results();
      $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Hang guard
   initial begin
      repeat (20000) @(posedge mclk);
      fail_count++;
      results();
   end

   // Main sequence
   initial begin
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      wr(8'h03, 8'hff);
      for (int i = 0; i < 10; i++) begin
         rd(rst_addr[i], rst_exp[i], "reset value");
      end
      chk("p1 oe after reset", 8'h00, p1_pin_oe);
      chk("p4 oe after reset", 8'h00, p4_pin_oe);
      chk("p4 gate after reset", 8'hff, p4_input_gate);
      chk("p5 oe after reset", 8'h00, {5'h00, p5_pin_oe});
      // Port1 latch and drive select, corner patterns first
      for (int i = 0; i < 12; i++) begin
         l = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
         d = (i < 2) ? ~l : 8'($random(seed));
         wr(P1_LATCH_OFS, l);
         wr(P1_DRIVE_OFS, d);
         @(negedge mclk);
         chk("p1 oe", (d | ~l) & 8'hdf, p1_pin_oe & 8'hdf);
         chk("p1 out", l & 8'hdf, p1_pin_out & 8'hdf);
         rd(P1_LATCH_OFS, l, "p1 latch");
         rd(P1_DRIVE_OFS, d, "p1 drive");
      end
      // Pin samples of port1 and port2
      wr(P1_LATCH_OFS, 8'hff);
      wr(P1_DRIVE_OFS, 8'h00);
      for (int i = 0; i < 6; i++) begin
         @(posedge mclk);
         ext1 <= 8'($random(seed));
         ext2 <= 3'($random(seed));
         repeat (2) @(posedge mclk);
         rd(P1_SAMPLE_OFS, ext1, "p1 pins");
         rd(P2_SAMPLE_OFS, {5'h00, ext2}, "p2 pins");
         chk("p1 func", ext1, p1_func_in);
      end
      // Timer invert, P15 route and chip enable
      @(posedge mclk);
      sio_data_out <= 1'b0;
      for (int i = 0; i < 2; i++) begin
         s = i ? 8'h00 : 8'hff;
         wr(TSS_OFS, s);
         rd(TSS_OFS, s & 8'ha1, "select reg");
         repeat (2) @(posedge mclk);
         @(negedge mclk);
         chk("timer3", {7'h00, ext1[0] ^ s[0]}, {7'h00, timer3_input});
         chk("p15 oe", {7'h00, ~s[5]}, {7'h00, p1_pin_oe[5]});
         chk("route", {7'h00, s[5]}, {7'h00, serial_pin_route});
         chk("chip sel", {7'h00, s[7] ? ext1[7] : 1'b1}, {7'h00, chip_select_n});
         chk("chip en", {7'h00, s[7]}, {7'h00, chip_enable_function});
      end
      // Port2 upper bits and stop release of P20
      wr(P2_LATCH_OFS, 8'hf8);
      rd(P2_LATCH_OFS, 8'h00, "p2 latch");
      chk("p2 out", 8'h00, {5'h00, p2_pin_out});
      for (int i = 0; i < 2; i++) begin
         @(posedge mclk);
         stop_mode <= (i == 1);
         @(negedge mclk);
         chk("p2 oe", i ? 8'h06 : 8'h07, {5'h00, p2_pin_oe});
      end
      @(posedge mclk);
      stop_mode <= 1'b0;
      wr(P2_LATCH_OFS, 8'h07);
      // One fall of P20 gives one pulse
      @(posedge mclk);
      ext2 <= 3'h7;
      repeat (5) @(posedge mclk);
      ext2 <= 3'h6;
      n = 8'h00;
      repeat (8) begin
         @(negedge mclk);
         n = n + {7'h00, p20_fall_event};
      end
      chk("p20 falls", 8'h01, n);
      // Port4 and port5 direction, gate and latch, analog setup first
      for (int i = 0; i < 10; i++) begin
         d = i ? 8'($random(seed)) : 8'h00;
         g = i ? 8'($random(seed)) : 8'h00;
         l = 8'($random(seed));
         wr(P4_DIR_OFS, d);
         wr(P4_GATE_OFS, g);
         wr(P4_LATCH_OFS, l);
         wr(P5_DIR_OFS, d);
         wr(P5_LATCH_OFS, l);
         @(posedge mclk);
         ext4 <= 8'($random(seed));
         ext5 <= 3'($random(seed));
         repeat (3) @(posedge mclk);
         @(negedge mclk);
         chk("p4 oe", d & (g | ~l), p4_pin_oe);
         chk("p4 out", d & l, d & p4_pin_out);
         chk("p4 gate", g, p4_input_gate);
         chk("p5 oe", {5'h00, d[2:0]}, {5'h00, p5_pin_oe});
         chk("p5 out", {5'h00, d[2:0] & l[2:0]}, {5'h00, d[2:0] & p5_pin_out});
         chk("p5 func", mix(d, l, {5'h00, ext5}) & 8'h07, {5'h00, p5_func_in});
         rd(P4_GATE_OFS, g, "p4 gate reg");
         rd(P4_LATCH_OFS, mix(d, l, ext4 & g), "p4 latch");
         rd(P5_DIR_OFS, {5'h00, d[2:0]}, "p5 dir");
         rd(P5_LATCH_OFS, mix(d, l, {5'h00, ext5}) & 8'h07, "p5 latch");
      end
      results();
   end
endmodule // pio_ports_tb

//--- pio_sync.sv
`timescale 1ns/1ns
// Two-stage synchroniser for asynchronous pin levels
module pio_sync #(
   parameter int W = 8
) (
   input  wire logic         mclk,  // System clock
   input  wire logic         rst,   // Asynchronous reset, active high
   input  wire logic [W-1:0] d,     // Raw pin levels
   output logic      [W-1:0] q      // Synchronised levels
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] meta_next;
   logic [W-1:0] q_next;

   // Shift pins through two stages; only the second stage is read
   always_comb begin
      meta_next = d;
      q_next    = meta_reg;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         meta_reg <= '0;
         q        <= '0;
      end else begin
         meta_reg <= meta_next;
         q        <= q_next;
      end
   end
endmodule // pio_sync
